// ===== scs_device.sv
// Converter end: conversion sequencing, channel selection, status pin, serial port.
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module scs_device (
    input  wire logic                clk,
    input  wire logic                resetn,
    scs_link_if.dev                  link,
    input  wire logic [13:0]         analog_ch0,
    input  wire logic [13:0]         analog_ch1,
    output logic                     hold_active,
    output logic [11:0]              config_word
);
    import scs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Every pin passes two flip-flops; the third stage only feeds edge detection.
    logic [3:0]     pin_s1_reg;
    logic [3:0]     pin_s2_reg;
    logic [3:0]     pin_s3_reg;
    logic           conversion_start_n_fall;
    logic           fs_fall;
    logic           fs_rise;
    logic           sclk_rise;
    logic           sclk_fall;
    logic           sdi_s;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_s1_reg <= PIN_IDLE;
            pin_s2_reg <= PIN_IDLE;
            pin_s3_reg <= PIN_IDLE;
        end else begin
            pin_s1_reg <= {link.conversion_start_n, link.frame_select_n, link.sclk, link.sdi};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // The start edge is taken whatever frame select does.
    assign conversion_start_n_fall = pin_s3_reg[3] & ~pin_s2_reg[3];
    assign fs_fall     = pin_s3_reg[2] & ~pin_s2_reg[2];
    assign fs_rise     = ~pin_s3_reg[2] & pin_s2_reg[2];
    assign sclk_rise   = ~pin_s3_reg[1] & pin_s2_reg[1];
    assign sclk_fall   = pin_s3_reg[1] & ~pin_s2_reg[1];
    assign sdi_s       = pin_s2_reg[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration and control state.
    logic [11:0]    cfg_reg;
    logic           manual_ch_reg;
    logic           auto_ch_reg;
    scs_dev_state_t state_reg;
    logic [4:0]     cnt_reg;
    logic [1:0]     osc_cnt_reg;
    logic           sclk_phase_reg;
    logic [13:0]    held_reg;
    logic           held_ch_reg;
    logic [15:0]    out_word_reg;
    logic           int_reg;
    logic           status_reg;
    logic [14:0]    shift_in_reg;
    logic [15:0]    shift_out_reg;
    logic [4:0]     bit_cnt_reg;
    logic           in_frame_reg;

    logic           use_sclk;
    logic           manual_trig;
    logic           osc_tick;
    logic           sclk_tick;
    logic           conversion_clock_tick;
    logic           cur_ch;
    logic           conv_start;
    logic           conv_done;
    logic           bit_take;
    logic [3:0]     cmd_now;
    logic [15:0]    word_now;
    logic           cmd_edge;
    logic           cfg_write;
    logic           eoc_asserted;
    logic           status_asserted;

    assign use_sclk    = ~cfg_reg[CFG_CLK_SRC];
    assign manual_trig = cfg_reg[CFG_TRIG];
    assign cur_ch      = cfg_reg[CFG_AUTO_CH] ? auto_ch_reg : manual_ch_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion clock: internal divider, stopped while the serial clock is the source.
    always_ff @(posedge clk) begin
        if (!resetn || use_sclk) begin
            osc_cnt_reg <= 2'h0;
        end else if (manual_trig && conversion_start_n_fall) begin
            // Restarting the divider at a manual start keeps every conversion equally long.
            osc_cnt_reg <= 2'h0;
        end else if (osc_cnt_reg == OSC_DIV_LAST) begin
            osc_cnt_reg <= 2'h0;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 2'h1;
        end
    end

    assign osc_tick = ~use_sclk & (osc_cnt_reg == OSC_DIV_LAST);

    // The halving phase restarts at the start edge, so a start set up ahead of a
    // serial clock rise converts in 36 serial clocks; a late one slips to 37.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sclk_phase_reg <= 1'b0;
        end else if (conversion_start_n_fall) begin
            sclk_phase_reg <= 1'b0;
        end else if (use_sclk && sclk_rise) begin
            sclk_phase_reg <= ~sclk_phase_reg;
        end
    end

    assign sclk_tick = use_sclk & sclk_rise & sclk_phase_reg;
    assign conversion_clock_tick = osc_tick | sclk_tick;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer: sample, acquisition and conversion phases.
    assign conv_start = (state_reg == DS_SAMPLE && manual_trig && conversion_start_n_fall)
                      | (state_reg == DS_ACQ && !manual_trig && conversion_clock_tick
                         && cnt_reg == ACQ_CCLKS - 5'h01);
    assign conv_done  = (state_reg == DS_CONV) && conversion_clock_tick
                      && (cnt_reg == CONV_CCLKS - 5'h01);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= DS_SAMPLE;
            cnt_reg   <= 5'h00;
        end else begin
            case (state_reg)
                DS_SAMPLE: begin
                    cnt_reg <= 5'h00;
                    if (conv_start) begin
                        state_reg <= DS_CONV;
                    end else if (!manual_trig && conversion_clock_tick) begin
                        // Entering on a clock tick makes the first acquisition full length.
                        state_reg <= DS_ACQ;
                    end
                end
                DS_ACQ: begin
                    if (manual_trig) begin
                        state_reg <= DS_SAMPLE;
                        cnt_reg   <= 5'h00;
                    end else if (conv_start) begin
                        state_reg <= DS_CONV;
                        cnt_reg   <= 5'h00;
                    end else if (conversion_clock_tick) begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
                DS_CONV: begin
                    if (conv_done) begin
                        state_reg <= manual_trig ? DS_SAMPLE : DS_ACQ;
                        cnt_reg   <= 5'h00;
                    end else if (conversion_clock_tick) begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
                default: begin
                    state_reg <= DS_SAMPLE;
                    cnt_reg   <= 5'h00;
                end
            endcase
        end
    end

    // Hold captures the selected input at the end of sampling.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            held_reg    <= 14'h0000;
            held_ch_reg <= 1'b0;
        end else if (conv_start) begin
            held_reg    <= cur_ch ? analog_ch1 : analog_ch0;
            held_ch_reg <= cur_ch;
        end
    end

    // Result with its channel tag waits for the next read frame.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            out_word_reg <= 16'h0000;
        end else if (conv_done) begin
            out_word_reg <= {held_reg, held_ch_reg, 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial port: bits are taken and presented on falling serial clock edges.
    assign bit_take = in_frame_reg & sclk_fall & (bit_cnt_reg < FRAME_BITS);
    assign cmd_now  = {shift_in_reg[2:0], sdi_s};
    assign word_now = {shift_in_reg, sdi_s};
    assign cmd_edge = bit_take & (bit_cnt_reg == CMD_BITS - 5'h01);
    assign cfg_write = bit_take & (bit_cnt_reg == FRAME_BITS - 5'h01)
                     & (word_now[15:12] == CMD_WR_CFG);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            in_frame_reg  <= 1'b0;
            bit_cnt_reg   <= 5'h00;
            shift_in_reg  <= 15'h0000;
            shift_out_reg <= 16'h0000;
        end else if (fs_fall) begin
            in_frame_reg  <= 1'b1;
            bit_cnt_reg   <= 5'h00;
            shift_out_reg <= out_word_reg;
        end else if (fs_rise) begin
            in_frame_reg <= 1'b0;
        end else if (bit_take) begin
            bit_cnt_reg   <= bit_cnt_reg + 5'h01;
            shift_in_reg  <= word_now[14:0];
            shift_out_reg <= {shift_out_reg[14:0], 1'b0};
        end
    end

    // A short frame is enough for a channel command.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            manual_ch_reg <= 1'b0;
        end else if (cmd_edge && (cmd_now == CMD_CH0 || cmd_now == CMD_CH1)) begin
            manual_ch_reg <= cmd_now[0];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cfg_reg <= CFG_RESET;
        end else if (cfg_write) begin
            cfg_reg <= word_now[11:0];
        end
    end

    // Turning automatic selection on restarts the sweep at channel 0.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            auto_ch_reg <= 1'b0;
        end else if (cfg_write && word_now[CFG_AUTO_CH] && !cfg_reg[CFG_AUTO_CH]) begin
            auto_ch_reg <= 1'b0;
        end else if (conv_start && cfg_reg[CFG_AUTO_CH]) begin
            auto_ch_reg <= ~auto_ch_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status pin. A conversion ending in the frame-start cycle keeps the interrupt set.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            int_reg <= 1'b0;
        end else if (conv_done) begin
            int_reg <= 1'b1;
        end else if (fs_fall) begin
            int_reg <= 1'b0;
        end
    end

    assign eoc_asserted = manual_trig ? (state_reg == DS_CONV)
                                      : (state_reg == DS_ACQ);
    assign status_asserted = cfg_reg[CFG_FUNC] ? eoc_asserted : int_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_reg <= 1'b1;
        end else begin
            status_reg <= cfg_reg[CFG_POL] ? ~status_asserted : status_asserted;
        end
    end

    assign link.sdo       = shift_out_reg[15];
    assign link.status_pin = status_reg;
    assign hold_active    = (state_reg == DS_CONV);
    assign config_word    = cfg_reg;

endmodule
`default_nettype wire

// ===== scs_pkg.sv
// Shared constants and types for the SAR conversion sequencer and its host.
package scs_pkg;

    localparam int CLK_HZ     = 50_000_000;
    localparam int CLK_NS     = 20;
    localparam int OSC_MIN_HZ = 21_000_000;
    localparam int OSC_DIV    = CLK_HZ / OSC_MIN_HZ;
    localparam logic [1:0] OSC_DIV_LAST = 2'(OSC_DIV - 1);

    localparam logic [4:0] ACQ_CCLKS  = 5'h03;
    localparam logic [4:0] CONV_CCLKS = 5'h12;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CMD_BITS   = 5'h04;

    localparam int CFG_AUTO_CH = 11;
    localparam int CFG_CLK_SRC = 10;
    localparam int CFG_TRIG    = 9;
    localparam int CFG_POL     = 7;
    localparam int CFG_FUNC    = 6;
    localparam logic [11:0] CFG_RESET = 12'hFFF;

    localparam logic [3:0] CMD_CH0    = 4'h0;
    localparam logic [3:0] CMD_CH1    = 4'h1;
    localparam logic [3:0] CMD_WR_CFG = 4'hE;

    // Pin order {conversion_start_n, frame_select_n, sclk, sdi}.
    localparam logic [3:0] PIN_IDLE = 4'hC;

    localparam logic [2:0] SCLK_HALF      = 3'h4;
    localparam int         CONVERSION_START_N_LOW_NS  = 40;
    localparam int         CONVERSION_START_N_LOW_CYC = (CONVERSION_START_N_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int         GAP_CCLKS      = 21;
    localparam int         CONVERSION_CLOCK_MAX_CYC   = 4 * int'(SCLK_HALF);
    localparam logic [8:0] GAP_LAST       = 9'(GAP_CCLKS * CONVERSION_CLOCK_MAX_CYC - 1);
    localparam logic [8:0] CONVERSION_START_N_RISE_AT = 9'(GAP_CCLKS * CONVERSION_CLOCK_MAX_CYC - CONVERSION_START_N_LOW_CYC);

    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_TX     = 4'h4;
    localparam logic [3:0] ADDR_RX     = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam int CTRL_GO     = 0;
    localparam int CTRL_SHORT  = 1;
    localparam int CTRL_CONVERSION_START_N = 2;

    typedef enum logic [2:0] {
        DS_SAMPLE = 3'b001,
        DS_ACQ    = 3'b010,
        DS_CONV   = 3'b100
    } scs_dev_state_t;

    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_LOW  = 4'b0010,
        HS_HIGH = 4'b0100,
        HS_END  = 4'b1000
    } scs_host_state_t;

endpackage

// ===== scs_link_if.sv
// Serial and control pins between the converter and its host.
`timescale 1ns/1ps
`default_nettype none
interface scs_link_if;
    logic sclk;
    logic frame_select_n;
    logic sdi;
    logic sdo;
    logic conversion_start_n;
    logic status_pin;

    modport dev (
        input  sclk,
        input  frame_select_n,
        input  sdi,
        input  conversion_start_n,
        output sdo,
        output status_pin
    );

    modport host (
        output sclk,
        output frame_select_n,
        output sdi,
        output conversion_start_n,
        input  sdo,
        input  status_pin
    );
endinterface
`default_nettype wire

// ===== scs_host.sv
// Host end: register port that drives serial frames and conversion starts.
`timescale 1ns/1ps
`default_nettype none
module scs_host (
    input  wire logic        clk,
    input  wire logic        resetn,
    scs_link_if.host         link,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);
    import scs_pkg::*;

    scs_host_state_t state_reg;
    logic [2:0]      half_reg;
    logic [4:0]      bit_cnt_reg;
    logic [15:0]     tx_reg;
    logic [15:0]     sh_reg;
    logic [15:0]     rx_reg;
    logic            short_reg;
    logic            sclk_reg;
    logic            fs_n_reg;
    logic            sdi_reg;
    logic            conversion_start_n_n_reg;
    logic [8:0]      gap_reg;
    logic [1:0]      in_s1_reg;
    logic [1:0]      in_s2_reg;
    logic            ctrl_wr;
    logic            go;
    logic            conversion_start_n_go;
    logic            half_done;
    logic [4:0]      nbits;

    assign ctrl_wr   = reg_wr & (reg_addr == ADDR_CTRL);
    assign go        = ctrl_wr & reg_wdata[CTRL_GO] & (state_reg == HS_IDLE);
    assign conversion_start_n_go = ctrl_wr & reg_wdata[CTRL_CONVERSION_START_N] & (gap_reg == 9'h000);
    assign half_done = (half_reg == SCLK_HALF - 3'h1);
    assign nbits     = short_reg ? CMD_BITS : FRAME_BITS;

    ////////////////////////////////////////////////////////////////////////////////
    // Pins from the converter pass two flip-flops: {sdo, status_pin}.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            in_s1_reg <= 2'h0;
            in_s2_reg <= 2'h0;
        end else begin
            in_s1_reg <= {link.sdo, link.status_pin};
            in_s2_reg <= in_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame engine: sdi changes on rising edges, sdo is taken on falling edges.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg   <= HS_IDLE;
            half_reg    <= 3'h0;
            bit_cnt_reg <= 5'h00;
            sh_reg      <= 16'h0000;
            rx_reg      <= 16'h0000;
            sclk_reg    <= 1'b0;
            fs_n_reg    <= 1'b1;
            sdi_reg     <= 1'b0;
        end else begin
            half_reg <= half_done ? 3'h0 : half_reg + 3'h1;
            case (state_reg)
                HS_IDLE: begin
                    half_reg <= 3'h0;
                    if (go) begin
                        fs_n_reg    <= 1'b0;
                        sh_reg      <= tx_reg;
                        sdi_reg     <= tx_reg[15];
                        bit_cnt_reg <= 5'h00;
                        state_reg   <= HS_LOW;
                    end
                end
                HS_LOW: begin
                    if (half_done) begin
                        if (bit_cnt_reg == nbits) begin
                            state_reg <= HS_END;
                        end else begin
                            sclk_reg  <= 1'b1;
                            sdi_reg   <= sh_reg[15];
                            state_reg <= HS_HIGH;
                        end
                    end
                end
                HS_HIGH: begin
                    if (half_done) begin
                        sclk_reg    <= 1'b0;
                        rx_reg      <= {rx_reg[14:0], in_s2_reg[1]};
                        sh_reg      <= {sh_reg[14:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        state_reg   <= HS_LOW;
                    end
                end
                HS_END: begin
                    fs_n_reg  <= 1'b1;
                    state_reg <= HS_IDLE;
                end
                default: begin
                    fs_n_reg  <= 1'b1;
                    sclk_reg  <= 1'b0;
                    state_reg <= HS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Start pulse: low for the least time, then a lockout of 21 slowest conversion clocks.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            gap_reg      <= 9'h000;
            conversion_start_n_n_reg <= 1'b1;
        end else if (conversion_start_n_go) begin
            gap_reg      <= GAP_LAST;
            conversion_start_n_n_reg <= 1'b0;
        end else begin
            if (gap_reg != 9'h000) begin
                gap_reg <= gap_reg - 9'h001;
            end
            if (gap_reg == CONVERSION_START_N_RISE_AT) begin
                conversion_start_n_n_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_reg    <= 16'h0000;
            short_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == ADDR_TX) begin
                tx_reg <= reg_wdata[15:0];
            end
            if (go) begin
                short_reg <= reg_wdata[CTRL_SHORT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            case (reg_addr)
                ADDR_TX:     reg_rdata <= {16'h0000, tx_reg};
                ADDR_RX:     reg_rdata <= {16'h0000, rx_reg};
                ADDR_STATUS: reg_rdata <= {29'h0000_0000, in_s2_reg[0],
                                           gap_reg != 9'h000, state_reg != HS_IDLE};
                default:     reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    assign link.sclk               = sclk_reg;
    assign link.frame_select_n     = fs_n_reg;
    assign link.sdi                = sdi_reg;
    assign link.conversion_start_n = conversion_start_n_n_reg;

endmodule
`default_nettype wire

// ===== scs_link_chk.sv
// Concurrent checks on the serial link between the converter and its host.
`timescale 1ns/1ps
`default_nettype none
module scs_link_chk (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        sclk,
    input wire logic        frame_select_n,
    input wire logic        conversion_start_n,
    input wire logic        status_pin,
    input wire logic        hold_active,
    input wire logic [11:0] config_word
);
    import scs_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    logic [8:0] low_cnt;
    logic [8:0] since_fall;
    logic [4:0] fall_cnt;
    logic       cs_q;
    logic       sclk_q;
    wire        man    = config_word[CFG_TRIG];
    wire        eoc_lo = config_word[CFG_FUNC] & config_word[CFG_POL];
    wire        int_lo = ~config_word[CFG_FUNC] & config_word[CFG_POL];
    wire        int_clk = config_word[CFG_CLK_SRC];
    // low_cnt and since_fall saturate, so a long idle span never wraps into a false short gap.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cs_q       <= 1'b1;
            sclk_q     <= 1'b0;
            low_cnt    <= 9'h000;
            since_fall <= 9'h1FF;
            fall_cnt   <= 5'h00;
        end else begin
            cs_q       <= conversion_start_n;
            sclk_q     <= sclk;
            low_cnt    <= status_pin ? 9'h000 : low_cnt + {8'h00, ~&low_cnt};
            since_fall <= (cs_q & ~conversion_start_n) ? 9'h000
                                                       : since_fall + {8'h00, ~&since_fall};
            fall_cnt   <= frame_select_n ? 5'h00 : fall_cnt + {4'h0, sclk_q & ~sclk};
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_start_low;
        $fell(conversion_start_n) |=> !conversion_start_n ##1 conversion_start_n;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start pulse width");
    property p_gap; $fell(conversion_start_n) |-> since_fall >= 9'h029; endproperty
    a_gap: assert property (p_gap) else $error("start edges too close");
    property p_hold; $fell(conversion_start_n) && man |-> ##[2:5] hold_active; endproperty
    a_hold: assert property (p_hold) else $error("no hold after start");
    property p_eoc_fall;
        $fell(conversion_start_n) && man && eoc_lo |-> ##[2:6] !status_pin;
    endproperty
    a_eoc_fall: assert property (p_eoc_fall) else $error("status late");
    // Lengths in system clocks only hold while the internal clock converts.
    property p_eoc_len;
        $rose(status_pin) && man && eoc_lo && int_clk |-> low_cnt == 9'h024;
    endproperty
    a_eoc_len: assert property (p_eoc_len) else $error("status length manual");
    property p_auto_len;
        $rose(status_pin) && !man && eoc_lo && int_clk |-> low_cnt == 9'h006;
    endproperty
    a_auto_len: assert property (p_auto_len) else $error("status length auto");
    property p_auto_per;
        $fell(status_pin) && !man && eoc_lo && int_clk
            |-> ##42 ($fell(status_pin) || man || !eoc_lo || !int_clk);
    endproperty
    a_auto_per: assert property (p_auto_per) else $error("auto period");
    property p_int; int_lo && !status_pin && frame_select_n |=> !status_pin; endproperty
    a_int: assert property (p_int) else $error("interrupt dropped");
    property p_frame; $rose(frame_select_n) |-> fall_cnt inside {5'h04, 5'h10}; endproperty
    a_frame: assert property (p_frame) else $error("frame edge count");
    c_int: cover property ($fell(status_pin) && int_lo);
    c_short: cover property ($rose(frame_select_n) && fall_cnt == 5'h04);
    c_auto: cover property ($fell(status_pin) && !man);
endmodule
`default_nettype wire

// ===== tb_sar_conversion_sequencer.sv
// Self-checking bench for the converter and host joined over the serial link.
`timescale 1ns/1ps
`default_nettype none
module tb_sar_conversion_sequencer;
    import scs_pkg::*;
    typedef struct packed {logic [3:0] ch; logic [13:0] a0; logic [13:0] a1; logic [15:0] rx;}
        scs_row_t;
    scs_row_t rows [4] = '{'{4'h0, 14'h1234, 14'h0F0F, 16'h48D0},
                           '{4'h1, 14'h3FFF, 14'h2AAA, 16'hAAAA},
                           '{4'h0, 14'h3FFF, 14'h0000, 16'hFFFC},
                           '{4'h1, 14'h1555, 14'h0001, 16'h0006}};
    logic        clk       = 1'b0;
    logic        resetn    = 1'b0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] s;
    logic [13:0] a0        = 14'h0;
    logic [13:0] a1        = 14'h0;
    logic        hold_active;
    logic [11:0] config_word;
    int          miscompares = 0;
    int          check_count = 0;
    scs_link_if link ();
    always #10 clk = ~clk;
    scs_device i_scs_device (.clk(clk), .resetn(resetn), .link(link), .analog_ch0(a0),
        .analog_ch1(a1), .hold_active(hold_active), .config_word(config_word));
    scs_host i_scs_host (.clk(clk), .resetn(resetn), .link(link), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    scs_link_chk i_scs_link_chk (.clk(clk), .resetn(resetn), .sclk(link.sclk),
        .frame_select_n(link.frame_select_n), .conversion_start_n(link.conversion_start_n),
        .status_pin(link.status_pin), .hold_active(hold_active), .config_word(config_word));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    // The poll is bounded, and a busy flag that never clears counts as a mismatch.
    task automatic frame(input logic [15:0] tx, input logic [31:0] go, output logic [31:0] rx);
        wr(ADDR_TX, {16'h0, tx});
        wr(ADDR_CTRL, go);
        s = 32'h1;
        for (int i = 0; i < 100 && s[0]; i++) rd(ADDR_STATUS, s);
        chk({31'h0, s[0]}, 32'h0);
        rd(ADDR_RX, rx);
    endtask
    task automatic results;
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk({27'h0, link.sclk, link.frame_select_n, link.conversion_start_n, link.status_pin,
             hold_active}, 32'hE);
        chk({20'h0, config_word}, 32'hFFF);
        rd(4'h2, s);
        chk(s, 32'h0);
        frame({CMD_WR_CFG, 12'h7FF}, 32'h1, s);
        foreach (rows[i]) begin
            a0 <= rows[i].a0;
            a1 <= rows[i].a1;
            frame({rows[i].ch, 12'h000}, 32'h3, s);
            wr(ADDR_CTRL, 32'h4);
            rd(ADDR_STATUS, s);
            chk({31'h0, s[1]}, 32'h1);
            wr(ADDR_CTRL, 32'h4);
            repeat (400) @(posedge clk);
            frame({rows[i].ch, 12'h000}, 32'h1, s);
            chk(s, {16'h0, rows[i].rx});
        end
        frame({CMD_WR_CFG, 12'hFFF}, 32'h1, s);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CTRL, 32'h4);
            repeat (400) @(posedge clk);
            frame(16'h2000, 32'h1, s);
            chk(s, k ? 32'h6 : 32'h5554);
        end
        frame({CMD_WR_CFG, 12'h7BF}, 32'h1, s);
        wr(ADDR_CTRL, 32'h4);
        repeat (100) @(posedge clk);
        rd(ADDR_STATUS, s);
        chk({31'h0, s[2]}, 32'h0);
        repeat (300) @(posedge clk);
        rd(ADDR_STATUS, s);
        chk({31'h0, s[2]}, 32'h0);
        frame(16'h2000, 32'h3, s);
        rd(ADDR_STATUS, s);
        chk({31'h0, s[2]}, 32'h1);
        frame({CMD_WR_CFG, 12'hDFF}, 32'h1, s);
        repeat (300) @(posedge clk);
        frame(16'h2000, 32'h1, s);
        chk({18'h0, s[15:2]}, {18'h0, s[1] ? a1 : a0});
        // Auto conversions finish during this frame, so the interrupt stands active high.
        frame({CMD_WR_CFG, 12'h73F}, 32'h1, s);
        repeat (100) @(posedge clk);
        rd(ADDR_STATUS, s);
        chk({31'h0, s[2]}, 32'h1);
        frame(16'h2000, 32'h3, s);
        rd(ADDR_STATUS, s);
        chk({31'h0, s[2]}, 32'h0);
        // Serial clock as source: 36 serial rises, so the third frame ends the conversion.
        a1 <= 14'h2345;
        frame({CMD_WR_CFG, 12'h3FF}, 32'h1, s);
        wr(ADDR_CTRL, 32'h4);
        for (int n = 0; n < 4; n++) begin
            frame(16'h2000, 32'h1, s);
            chk({31'h0, hold_active}, (n < 2) ? 32'h1 : 32'h0);
        end
        chk(s, 32'h8D16);
        results();
    end
endmodule
`default_nettype wire
